// ===== core/tcc_pkg.sv
// Package for the sixteen-bit capture/compare timer: modes, reset values.
// Assumes a single clock domain; no register bus.
package tcc_pkg;
  localparam int          CNT_W        = 16;
  localparam logic [15:0] CNT_RST      = 16'h0000;
  localparam logic [15:0] CNT_MAX      = 16'hFFFF;
  localparam logic [15:0] CNT_ONE      = 16'h0001;
  localparam int          ESEL_B_HI    = 6;
  localparam int          ESEL_B_LO    = 5;
  localparam int          OVF_BIT      = 0;

  typedef enum logic [1:0] {
    TCC_MODE_STOP   = 2'b00,
    TCC_MODE_FREE   = 2'b01,
    TCC_MODE_CLRTIA = 2'b10,
    TCC_MODE_CLRMAT = 2'b11
  } tcc_mode_t;

  // Edge selection: 00 falling, 01 rising, 10 none, 11 both
  typedef enum logic [1:0] {
    TCC_EDGE_FALL = 2'b00,
    TCC_EDGE_RISE = 2'b01,
    TCC_EDGE_NONE = 2'b10,
    TCC_EDGE_BOTH = 2'b11
  } tcc_edge_t;

  typedef struct packed {
    tcc_mode_t   mode;
    tcc_edge_t   edgeA;
    tcc_edge_t   edgeB;
    logic        capAOpposite;
    logic        toggleEnable;
  } tcc_cfg_t;

  typedef struct packed {
    logic [15:0] mainCounter;
    logic [15:0] capcompRegA;
    logic [15:0] capcompRegB;
    logic        overflowFlag;
    logic        toggleOutput;
    logic        matchIrqA;
    logic        matchIrqB;
    logic        trigAPrev;
    logic        trigBPrev;
  } tcc_state_t;
endpackage : tcc_pkg

// ===== core/tcc_timer16.sv
// Sixteen-bit timer with two capture/compare registers and two triggers.
// Assumes trigger pins are synchronous to ref_clk; countTick is the
// prescaled count clock as a one-cycle enable.
//
// Contract
// - Clear-and-start: valid edge on trigger A captures count into reg B, clears.
// - Mode field 10 selects clear-and-start on trigger A valid edge.
// - Reg A may capture on trigger A edge opposite its valid edge.
// - Opposite-phase capture into reg A raises no match interrupt A.
// - Then trigger B valid edge captures nothing but raises match interrupt A.
// - Counter equal to reg A raises interrupt A, toggles output if enabled.
// - Compare zero: no match right after start; first match at 0 to 1.
// - Same zero-compare timing after overflow, trigger A, or match clear.
// - Reg B holds one input period when no overflow occurred.
// - Reg B captures on trigger A detection in every mode but stop.
`timescale 1ns/1ps
`default_nettype none
module tcc_timer16 (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst_b,
  // Configuration
  input  wire tcc_pkg::tcc_cfg_t cfg,
  input  wire logic              countTick,
  input  wire logic              ovfClear,
  input  wire logic              loadA,
  input  wire logic              loadB,
  input  wire logic [15:0]       loadValue,
  // Trigger pins
  input  wire logic              trigger_input_a,
  input  wire logic              trigger_input_b,
  // Outputs
  output logic [15:0]            main_counter,
  output logic [15:0]            capcomp_reg_a,
  output logic [15:0]            capcomp_reg_b,
  output logic                   overflow_flag,
  output logic                   toggle_output,
  output logic                   match_irq_a,
  output logic                   match_irq_b
);
  tcc_pkg::tcc_state_t st;
  tcc_pkg::tcc_state_t next_st;

  logic        aValid;
  logic        aOpp;
  logic        bValid;
  logic        running;
  logic        clrOnTrigA;
  logic        clrOnMatch;
  logic        capAOnOpp;
  logic        matchA;
  logic        matchB;
  logic [16:0] stepSum;
  logic [15:0] stepCount;

  // Trigger edge decode
  tcc_edge_sel i_edgeA (
    .pin      (trigger_input_a),
    .pinPrev  (st.trigAPrev),
    .sel      (cfg.edgeA),
    .validHit (aValid),
    .oppHit   (aOpp)
  );

  tcc_edge_sel i_edgeB (
    .pin      (trigger_input_b),
    .pinPrev  (st.trigBPrev),
    .sel      (cfg.edgeB),
    .validHit (bValid),
    .oppHit   ()
  );

  // Mode decode
  always_comb begin
    running    = 1'b0;
    clrOnTrigA = 1'b0;
    clrOnMatch = 1'b0;
    case (cfg.mode)
      tcc_pkg::TCC_MODE_FREE: begin
        running = 1'b1;
      end
      tcc_pkg::TCC_MODE_CLRTIA: begin
        running    = 1'b1;
        clrOnTrigA = 1'b1;
      end
      tcc_pkg::TCC_MODE_CLRMAT: begin
        running    = 1'b1;
        clrOnMatch = 1'b1;
      end
      default: begin
        running = 1'b0;
      end
    endcase
    // Reg A turns capture register on the opposite trigger A edge
    capAOnOpp = clrOnTrigA & cfg.capAOpposite;
  end

  always_comb begin
    stepSum   = {1'b0, st.mainCounter} + {16'h0000, countTick};
    stepCount = stepSum[15:0];
    // Pre-step compare: a zero compare first fires on the 0 to 1 step
    matchA = running && countTick && !capAOnOpp
             && st.mainCounter == st.capcompRegA;
    // Reg B is a capture register in clear-on-trigger-A mode
    matchB = running && countTick && !clrOnTrigA
             && st.mainCounter == st.capcompRegB;
    next_st           = st;
    next_st.trigAPrev = trigger_input_a;
    next_st.trigBPrev = trigger_input_b;
    next_st.matchIrqA = 1'b0;
    next_st.matchIrqB = 1'b0;
    if (loadA) begin
      next_st.capcompRegA = loadValue;
    end
    if (loadB) begin
      next_st.capcompRegB = loadValue;
    end
    if (ovfClear) begin
      next_st.overflowFlag = 1'b0;
    end
    if (!running) begin
      next_st.mainCounter = tcc_pkg::CNT_RST;
    end else begin
      next_st.mainCounter = stepCount;
      if (matchA) begin
        next_st.matchIrqA = 1'b1;
        if (cfg.toggleEnable) begin
          next_st.toggleOutput = ~st.toggleOutput;
        end
        if (clrOnMatch) begin
          next_st.mainCounter = tcc_pkg::CNT_RST;
        end
      end
      if (matchB) begin
        next_st.matchIrqB = 1'b1;
      end
      // Captures take the count this tick produces, so widths are exact
      if (capAOnOpp && aOpp) begin
        next_st.capcompRegA = stepCount;
      end
      if (capAOnOpp && bValid) begin
        next_st.matchIrqA = 1'b1;
      end
      if (aValid) begin
        // Capture interrupt on reg B; wins over a same-cycle load
        next_st.capcompRegB = stepCount;
        next_st.matchIrqB   = 1'b1;
        if (clrOnTrigA) begin
          next_st.mainCounter = tcc_pkg::CNT_RST;
        end
      end
    end
    // Hardware overflow set wins over a software clear
    if (running && stepSum[16]) begin
      next_st.overflowFlag = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st           <= '0;
      // Pin A idles high; avoids a false edge after reset
      st.trigAPrev <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign main_counter  = st.mainCounter;
  assign capcomp_reg_a = st.capcompRegA;
  assign capcomp_reg_b = st.capcompRegB;
  assign overflow_flag = st.overflowFlag;
  assign toggle_output = st.toggleOutput;
  assign match_irq_a   = st.matchIrqA;
  assign match_irq_b   = st.matchIrqB;
endmodule : tcc_timer16

// Edge decode for one trigger pin against its previous sample
module tcc_edge_sel (
  // Pin and its previous sample
  input  wire logic               pin,
  input  wire logic               pinPrev,
  // Selected valid edge
  input  wire tcc_pkg::tcc_edge_t sel,
  // Decoded edges
  output logic                    validHit,
  output logic                    oppHit
);
  logic rise;
  logic fall;

  always_comb begin
    rise = pin & ~pinPrev;
    fall = ~pin & pinPrev;
    case (sel)
      tcc_pkg::TCC_EDGE_FALL: begin
        validHit = fall;
        oppHit   = rise;
      end
      tcc_pkg::TCC_EDGE_RISE: begin
        validHit = rise;
        oppHit   = fall;
      end
      tcc_pkg::TCC_EDGE_BOTH: begin
        validHit = rise | fall;
        oppHit   = 1'b0;
      end
      default: begin
        validHit = 1'b0;
        oppHit   = 1'b0;
      end
    endcase
  end
endmodule : tcc_edge_sel
`default_nettype wire

// ===== tb/tcc_timer16_chk.sv
// Assertions on the timer's ports.
// Assumes one clock domain and asynchronous reset rst_b.
`timescale 1ns/1ps
`default_nettype none
module tcc_timer16_chk (
  // Watched ports
  input wire logic              ref_clk,
  input wire logic              rst_b,
  input wire tcc_pkg::tcc_cfg_t cfg,
  input wire logic              countTick,
  input wire logic              trigger_input_a,
  input wire logic              trigger_input_b,
  input wire logic [15:0]       main_counter,
  input wire logic [15:0]       capcomp_reg_a,
  input wire logic [15:0]       capcomp_reg_b,
  input wire logic              overflow_flag,
  input wire logic              toggle_output,
  input wire logic              match_irq_a
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  wire logic freeRun = cfg.mode == tcc_pkg::TCC_MODE_FREE;
  wire logic clrRun  = cfg.mode == tcc_pkg::TCC_MODE_CLRTIA;
  wire logic oppCap  = clrRun && cfg.capAOpposite
                       && cfg.edgeA == tcc_pkg::TCC_EDGE_FALL;
  sequence s_fallA;
    clrRun && cfg.edgeA == tcc_pkg::TCC_EDGE_FALL && $fell(trigger_input_a);
  endsequence
  sequence s_riseA;
    oppCap && $rose(trigger_input_a);
  endsequence
  property p_clr;
    s_fallA |=> main_counter == 16'h0000
                && capcomp_reg_b == $past(main_counter + {15'h0000, countTick});
  endproperty
  a_clr: assert property (p_clr)
    else $error("no capture and clear");
  property p_capa;
    s_riseA |=> capcomp_reg_a == $past(main_counter + {15'h0000, countTick});
  endproperty
  a_capa: assert property (p_capa)
    else $error("no opposite edge capture");
  property p_noirqa;
    oppCap && $rose(trigger_input_a) && !$rose(trigger_input_b)
      |=> !match_irq_a;
  endproperty
  a_noirqa: assert property (p_noirqa)
    else $error("interrupt on opposite capture");
  property p_bedge;
    oppCap && cfg.edgeB == tcc_pkg::TCC_EDGE_RISE && $rose(trigger_input_b)
      && !$rose(trigger_input_a) |=> match_irq_a && $stable(capcomp_reg_a);
  endproperty
  a_bedge: assert property (p_bedge)
    else $error("second trigger misbehaves");
  property p_match;
    freeRun && countTick && capcomp_reg_a != 16'h0000
      && main_counter == capcomp_reg_a |=> match_irq_a
      && toggle_output == ($past(toggle_output) ^ $past(cfg.toggleEnable));
  endproperty
  a_match: assert property (p_match)
    else $error("missing match");
  property p_zero;
    freeRun && countTick && main_counter == 16'h0000
      && capcomp_reg_a == 16'h0000 |=> match_irq_a;
  endproperty
  a_zero: assert property (p_zero)
    else $error("zero compare missed its first step");
  property p_ovf;
    freeRun && countTick && main_counter == 16'hFFFF
      |=> main_counter == 16'h0000 ##0 overflow_flag;
  endproperty
  a_ovf: assert property (p_ovf)
    else $error("bad wrap");
  property p_inc;
    freeRun && countTick |=> main_counter == $past(main_counter) + 16'h0001;
  endproperty
  a_inc: assert property (p_inc)
    else $error("bad count step");
endmodule : tcc_timer16_chk
`default_nettype wire

// ===== tb/tcc_pulse_src.sv
// Pulse sources on both trigger pins.
// Assumes ref_clk; pin A idles high while run is low.
`timescale 1ns/1ps
`default_nettype none
module tcc_pulse_src (
  // Clock and control
  input  wire logic       ref_clk,
  input  wire logic       run,
  input  wire logic       pulseB,
  input  wire logic [7:0] lowLen,
  input  wire logic [7:0] highLen,
  // Trigger pins
  output logic            trigger_input_a,
  output logic            trigger_input_b
);
  logic [7:0] phase = 8'h00;
  always_ff @(posedge ref_clk) begin
    if (!run || phase == lowLen + highLen - 8'h01) phase <= 8'h00;
    else phase <= phase + 8'h01;
    trigger_input_a <= !run || phase >= lowLen;
    trigger_input_b <= pulseB;
  end
endmodule : tcc_pulse_src
`default_nettype wire

// ===== tb/tcc_timer16_tb.sv
// Testbench for the capture/compare timer.
// Assumes the pulse source model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module tcc_timer16_tb;
  logic ref_clk = 1'b0, rst_b = 1'b0, loadA = 1'b0, run = 1'b0, pulseB = 1'b0;
  logic ovfClear = 1'b0;
  logic [15:0] loadValue = 16'h0000;
  logic [15:0] main_counter, capcomp_reg_a, capcomp_reg_b;
  logic overflow_flag, toggle_output, match_irq_a, match_irq_b;
  logic trigger_input_a, trigger_input_b;
  tcc_pkg::tcc_cfg_t cfg = '0;
  int badCount = 0, samplesChecked = 0;
  tcc_timer16 i_dut (.ref_clk, .rst_b, .cfg, .countTick(1'b1),
    .ovfClear, .loadA, .loadB(1'b0), .loadValue, .trigger_input_a,
    .trigger_input_b, .main_counter, .capcomp_reg_a, .capcomp_reg_b,
    .overflow_flag, .toggle_output, .match_irq_a, .match_irq_b);
  tcc_pulse_src i_src (.ref_clk, .run, .pulseB, .lowLen(8'h06),
    .highLen(8'h0A), .trigger_input_a, .trigger_input_b);
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      badCount++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic completeRun;
    $display("compares %0d mismatches %0d", samplesChecked, badCount);
    if (badCount == 0 && samplesChecked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : completeRun
  task automatic waitHi(ref logic sig, input int lim);
    int k;
    for (k = 0; k < lim; k++) begin
      @(negedge ref_clk);
      if (sig === 1'b1) break;
    end
    if (k == lim) begin
      chk({15'h0000, sig}, 16'h0001);
      completeRun();
    end
  endtask : waitHi
  initial forever #2.5 ref_clk = ~ref_clk;
  initial begin
    cfg <= '{tcc_pkg::TCC_MODE_FREE, tcc_pkg::TCC_EDGE_FALL,
             tcc_pkg::TCC_EDGE_RISE, 1'b0, 1'b0};
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge ref_clk);
    cfg.mode <= tcc_pkg::TCC_MODE_STOP;
    loadA <= 1'b1;
    loadValue <= 16'h0005;
    @(posedge ref_clk);
    loadA <= 1'b0;
    cfg.toggleEnable <= 1'b1;
    cfg.mode <= tcc_pkg::TCC_MODE_FREE;
    waitHi(match_irq_a, 20);
    chk(main_counter, 16'h0006);
    chk({15'h0000, toggle_output}, 16'h0001);
    waitHi(overflow_flag, 70000);
    chk(main_counter, 16'h0000);
    @(posedge ref_clk);
    ovfClear <= 1'b1;
    @(posedge ref_clk);
    ovfClear <= 1'b0;
    cfg <= '{tcc_pkg::TCC_MODE_CLRTIA, tcc_pkg::TCC_EDGE_FALL,
             tcc_pkg::TCC_EDGE_RISE, 1'b1, 1'b0};
    run <= 1'b1;
    waitHi(match_irq_b, 40);
    waitHi(match_irq_b, 40);
    chk(capcomp_reg_b, 16'h0010);
    chk(capcomp_reg_a, 16'h0006);
    chk({15'h0000, overflow_flag}, 16'h0000);
    @(posedge ref_clk);
    pulseB <= 1'b1;
    waitHi(match_irq_a, 8);
    chk(capcomp_reg_a, 16'h0006);
    completeRun();
  end
endmodule : tcc_timer16_tb
bind tcc_timer16 tcc_timer16_chk i_chk (.ref_clk, .rst_b, .cfg, .countTick,
  .trigger_input_a, .trigger_input_b, .main_counter, .capcomp_reg_a,
  .capcomp_reg_b, .overflow_flag, .toggle_output, .match_irq_a);
`default_nettype wire
